/* File: src/gpt_map.svh */
// Register offsets, field positions, reset values and counts of the timer
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define GPT_OFS_CONFIG 8'h00
`define GPT_OFS_MODE_A 8'h04
`define GPT_OFS_MODE_B 8'h08
`define GPT_OFS_CONTROL 8'h0C
`define GPT_OFS_MASK 8'h18
`define GPT_OFS_RAW 8'h1C
`define GPT_OFS_MASKED 8'h20
`define GPT_OFS_CLEAR 8'h24
`define GPT_OFS_LOAD_A 8'h28
`define GPT_OFS_LOAD_B 8'h2C
`define GPT_OFS_MATCH_A 8'h30
`define GPT_OFS_PRESCALE_A 8'h38
`define GPT_OFS_PRESCALE_B 8'h3C
`define GPT_OFS_VALUE_A 8'h48
`define GPT_OFS_VALUE_B 8'h4C
// ****************************************
// Field positions
// ****************************************
`define GPT_CTL_EN_A 0
`define GPT_CTL_STALL_A 1
`define GPT_CTL_CLK_STALL_EN 4
`define GPT_CTL_EN_B 8
`define GPT_CTL_STALL_B 9
`define GPT_IRQ_TO_A 0
`define GPT_IRQ_MATCH 3
`define GPT_IRQ_TO_B 8
// ****************************************
// Encodings and reset values
// ****************************************
`define GPT_CFG_JOINED 3'h0
`define GPT_CFG_CLOCK 3'h1
`define GPT_CFG_SPLIT 3'h4
`define GPT_MODE_ONESHOT 2'h1
`define GPT_MODE_PERIODIC 2'h2
`define GPT_RST_COUNT 16'hFFFF
`define GPT_RST_PRESCALE 8'h00
`define GPT_RTC_START 32'h00000001
`define GPT_SLOW_CLK_HZ 32768
`define GPT_TICK_HZ 1
`define GPT_RTC_DIV (`GPT_SLOW_CLK_HZ / `GPT_TICK_HZ)
`endif

/* File: src/gpt_pkg.sv */
// Types and shared helpers of the timer pair
package gpt_pkg;
	typedef enum logic [1:0] {
		GPT_JOINED,
		GPT_CLOCK,
		GPT_SPLIT
	} gpt_cfg_t;

	function automatic gpt_cfg_t gpt_decode_cfg(input logic [2:0] v);
		gpt_cfg_t m;
		case (v)
			3'h0: m = GPT_JOINED;
			3'h1: m = GPT_CLOCK;
			default: m = GPT_SPLIT;
		endcase
		return m;
	endfunction : gpt_decode_cfg

	function automatic logic gpt_is_oneshot(input logic [1:0] mf);
		return mf == 2'h1;
	endfunction : gpt_is_oneshot
endpackage : gpt_pkg

/* File: src/gpt_rtc_div.sv */
// Divider from the slow capture-pin clock to a one-second tick
`timescale 1ns/1ps
module gpt_rtc_div import gpt_pkg::*; #(
	parameter int DIV = 32768
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_run,
	input wire logic i_capture_pin,
	output logic o_tick
);
	localparam int CW = $clog2(DIV);
	logic [2:0] sync_r;
	logic [CW-1:0] edge_cnt_r;
	logic pin_lvl_r;

	// ****************************************
	// Pin synchroniser
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_r <= 3'h0;
			pin_lvl_r <= 1'b0;
		end else if (i_ce) begin
			sync_r <= {sync_r[1:0], i_capture_pin};
			// Level moves only once stages 1 and 2 agree
			if (sync_r[1] == sync_r[2]) begin
				pin_lvl_r <= sync_r[2];
			end
		end
	end

	// ****************************************
	// Edge counter
	// ****************************************
	// Rising edge counts when both late stages agree on high
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			edge_cnt_r <= '0;
			o_tick <= 1'b0;
		end else if (i_ce) begin
			o_tick <= 1'b0;
			if (!i_run) begin
				edge_cnt_r <= '0;
			end else if (sync_r[1] && sync_r[2] && !pin_lvl_r) begin
				if (edge_cnt_r == CW'(DIV - 1)) begin // [R13]
					edge_cnt_r <= '0;
					o_tick <= 1'b1;
				end else begin
					edge_cnt_r <= edge_cnt_r + 1'b1;
				end
			end
		end
	end
endmodule : gpt_rtc_div

/* File: src/gpt_top.sv */
// Timer pair top: register port, counters, flags and interrupt
// Behaviour
// R01 - Reset: idle, counters and loads all ones
// R02 - Reset: both prescale registers zero
// R03 - Config 0 joined timer, 1 clock
// R04 - Joined mode: load write fills both halves
// R05 - Joined mode: value read joins both halves
// R06 - Joined mode: only first mode field counts
// R07 - Joined counts down, reloads after zero
// R08 - One-shot stops and clears enable
// R09 - Zero sets sticky timeout flag, masked view
// R10 - Load rewrite taken next cycle
// R11 - Stall bit freezes counter during halt
// R12 - Clock mode counts up, starts at one
// R13 - Slow pin clock divided to seconds
// R14 - Count equal match rolls to zero
// R15 - Match sets flag, interrupt, clear bit
// R16 - Clock stall enable overrides stall bits
// R17 - Config 4 gives two independent counters
// R18 - Split counter with eight-bit prescaler
// R19 - Split counter reloads load and prescale
// R20 - Split zero sets sticky timeout flag
// R21 - Prescale P gives P+1 clocks per step
// R22 - Everything on the one system clock
`timescale 1ns/1ps
`include "gpt_map.svh"
module gpt_top import gpt_pkg::*; #(
	parameter int RTC_DIV = `GPT_RTC_DIV
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_halt,
	input wire logic i_capture_pin,
	output logic [31:0] o_rd_data,
	output logic o_irq
);
	logic [1:0] rst_sync_r;
	logic rst_b;
	logic [2:0] cfg_r;
	logic [1:0] mode_a_r;
	logic [1:0] mode_b_r;
	logic [9:0] ctl_r;
	logic [8:0] mask_r;
	logic [8:0] raw_r;
	logic [15:0] load_a_r;
	logic [15:0] load_b_r;
	logic [31:0] match_r;
	logic [7:0] pscl_a_r;
	logic [7:0] pscl_b_r;
	logic [15:0] cnt_a_r;
	logic [15:0] cnt_b_r;
	logic [7:0] pcnt_a_r;
	logic [7:0] pcnt_b_r;
	gpt_cfg_t cfg;
	logic wr_cfg, wr_ctl, wr_load_a, wr_load_b, wr_clr;
	logic en_a, en_b, frz_a, frz_b, rtc_tick;
	logic step_a, step_b, zero_a, zero_b, step_j, zero_j, hit_rtc;
	logic done_a, done_b, rtc_first;
	logic [31:0] cnt_j;
	logic [8:0] set_raw;
	logic [31:0] rd_nxt;

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_r[1];

	// ****************************************
	// Decode
	// ****************************************
	assign cfg = gpt_decode_cfg(cfg_r); // [R03] [R17]
	assign wr_cfg = i_wr && i_addr == `GPT_OFS_CONFIG;
	assign wr_ctl = i_wr && i_addr == `GPT_OFS_CONTROL;
	assign wr_load_a = i_wr && i_addr == `GPT_OFS_LOAD_A;
	assign wr_load_b = i_wr && i_addr == `GPT_OFS_LOAD_B;
	assign wr_clr = i_wr && i_addr == `GPT_OFS_CLEAR;
	assign en_a = ctl_r[`GPT_CTL_EN_A];
	assign en_b = ctl_r[`GPT_CTL_EN_B];
	assign rtc_first = wr_cfg && i_wr_data[2:0] == `GPT_CFG_CLOCK &&
		cfg_r != `GPT_CFG_CLOCK;

	// ****************************************
	// Debug stall
	// ****************************************
	always_comb begin
		frz_a = i_halt && ctl_r[`GPT_CTL_STALL_A]; // [R11]
		frz_b = i_halt && ctl_r[`GPT_CTL_STALL_B]; // [R11]
		if (cfg == GPT_CLOCK) begin
			// Either stall bit halts the clock unless overridden
			frz_a = i_halt && (ctl_r[`GPT_CTL_STALL_A] ||
				ctl_r[`GPT_CTL_STALL_B]) &&
				!ctl_r[`GPT_CTL_CLK_STALL_EN]; // [R16]
		end
	end

	// ****************************************
	// Second tick
	// ****************************************
	gpt_rtc_div #(
		.DIV(RTC_DIV)
	) u_div (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(rst_b),
		.i_ce(i_ce),
		.i_run(cfg == GPT_CLOCK && en_a),
		.i_capture_pin(i_capture_pin),
		.o_tick(rtc_tick)
	);

	// ****************************************
	// Count events
	// ****************************************
	assign cnt_j = {cnt_b_r, cnt_a_r}; // [R05]
	assign zero_j = cnt_j == 32'h00000000;
	assign step_j = cfg == GPT_JOINED && en_a && !frz_a;
	assign hit_rtc = cfg == GPT_CLOCK && en_a && !frz_a && rtc_tick &&
		cnt_j == match_r;
	// Prescaler at zero marks the last clock of a step
	assign step_a = cfg == GPT_SPLIT && en_a && !frz_a &&
		pcnt_a_r == 8'h00; // [R21]
	assign step_b = cfg == GPT_SPLIT && en_b && !frz_b &&
		pcnt_b_r == 8'h00; // [R21]
	assign zero_a = cnt_a_r == 16'h0000;
	assign zero_b = cnt_b_r == 16'h0000;
	always_comb begin
		done_a = 1'b0;
		done_b = 1'b0;
		if (step_j && zero_j) begin
			done_a = gpt_is_oneshot(mode_a_r); // [R06] [R08]
		end
		if (step_a && zero_a) begin
			done_a = gpt_is_oneshot(mode_a_r); // [R19]
		end
		if (step_b && zero_b) begin
			done_b = gpt_is_oneshot(mode_b_r); // [R19]
		end
	end
	always_comb begin
		set_raw = 9'h000;
		set_raw[`GPT_IRQ_TO_A] = (step_j && zero_j) ||
			(step_a && zero_a); // [R09] [R20]
		set_raw[`GPT_IRQ_TO_B] = step_b && zero_b; // [R20]
		set_raw[`GPT_IRQ_MATCH] = hit_rtc; // [R15]
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= `GPT_CFG_JOINED; // [R01]
			mode_a_r <= 2'h0;
			mode_b_r <= 2'h0;
			mask_r <= 9'h000;
			match_r <= 32'hFFFFFFFF;
		end else if (i_ce) begin
			if (wr_cfg) begin
				cfg_r <= i_wr_data[2:0];
			end
			if (i_wr && i_addr == `GPT_OFS_MODE_A) begin
				mode_a_r <= i_wr_data[1:0];
			end
			if (i_wr && i_addr == `GPT_OFS_MODE_B) begin
				mode_b_r <= i_wr_data[1:0];
			end
			if (i_wr && i_addr == `GPT_OFS_MASK) begin
				mask_r <= i_wr_data[8:0];
			end
			if (i_wr && i_addr == `GPT_OFS_MATCH_A) begin
				match_r <= i_wr_data;
			end
		end
	end

	// ****************************************
	// Control and enables
	// ****************************************
	// A software write in the same cycle as a one-shot end wins
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_r <= 10'h000; // [R01]
		end else if (i_ce) begin
			if (wr_ctl) begin
				ctl_r <= i_wr_data[9:0];
			end else begin
				if (done_a) begin
					ctl_r[`GPT_CTL_EN_A] <= 1'b0; // [R08]
				end
				if (done_b) begin
					ctl_r[`GPT_CTL_EN_B] <= 1'b0; // [R19]
				end
			end
		end
	end

	// ****************************************
	// Load and prescale registers
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			load_a_r <= `GPT_RST_COUNT; // [R01]
			load_b_r <= `GPT_RST_COUNT; // [R01]
			pscl_a_r <= `GPT_RST_PRESCALE; // [R02]
			pscl_b_r <= `GPT_RST_PRESCALE; // [R02]
		end else if (i_ce) begin
			if (wr_load_a) begin
				load_a_r <= i_wr_data[15:0];
				if (cfg != GPT_SPLIT) begin
					load_b_r <= i_wr_data[31:16]; // [R04]
				end
			end else if (wr_load_b) begin
				load_b_r <= i_wr_data[15:0];
			end
			if (i_wr && i_addr == `GPT_OFS_PRESCALE_A) begin
				pscl_a_r <= i_wr_data[7:0]; // [R18]
			end
			if (i_wr && i_addr == `GPT_OFS_PRESCALE_B) begin
				pscl_b_r <= i_wr_data[7:0]; // [R18]
			end
		end
	end

	// ****************************************
	// First counter and joined counter
	// ****************************************
	// The joined modes drive the low half from here; the second counter block drives the high half [R22]
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_a_r <= `GPT_RST_COUNT; // [R01]
			pcnt_a_r <= `GPT_RST_PRESCALE;
		end else if (i_ce) begin
			if (rtc_first) begin
				cnt_a_r <= 16'(`GPT_RTC_START); // [R12]
			end else if (wr_load_a && cfg != GPT_CLOCK) begin
				cnt_a_r <= i_wr_data[15:0]; // [R10]
				pcnt_a_r <= pscl_a_r;
			end else begin
				case (cfg)
					GPT_JOINED: begin
						if (step_j) begin
							cnt_a_r <= zero_j ? load_a_r :
								cnt_a_r - 1'b1; // [R07]
						end
					end
					GPT_CLOCK: begin
						if (hit_rtc) begin
							cnt_a_r <= 16'h0000; // [R14]
						end else if (en_a && !frz_a && rtc_tick) begin
							cnt_a_r <= cnt_a_r + 1'b1; // [R12]
						end
					end
					GPT_SPLIT: begin
						if (en_a && !frz_a) begin
							pcnt_a_r <= step_a ? pscl_a_r :
								pcnt_a_r - 1'b1; // [R21]
						end
						if (step_a) begin
							cnt_a_r <= zero_a ? load_a_r :
								cnt_a_r - 1'b1; // [R19]
						end
					end
					default: begin
						cnt_a_r <= cnt_a_r;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Second counter
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_b_r <= `GPT_RST_COUNT; // [R01]
			pcnt_b_r <= `GPT_RST_PRESCALE;
		end else if (i_ce) begin
			if (rtc_first) begin
				cnt_b_r <= 16'h0000; // [R12]
			end else if (cfg == GPT_JOINED && wr_load_a) begin
				cnt_b_r <= i_wr_data[31:16]; // [R10]
			end else if (cfg == GPT_SPLIT && wr_load_b) begin
				cnt_b_r <= i_wr_data[15:0]; // [R10]
				pcnt_b_r <= pscl_b_r;
			end else begin
				case (cfg)
					GPT_JOINED: begin
						if (step_j && zero_j) begin
							cnt_b_r <= load_b_r; // [R07]
						end else if (step_j && zero_a) begin
							cnt_b_r <= cnt_b_r - 1'b1;
						end
					end
					GPT_CLOCK: begin
						if (hit_rtc) begin
							cnt_b_r <= 16'h0000; // [R14]
						end else if (en_a && !frz_a && rtc_tick &&
							cnt_a_r == 16'hFFFF) begin
							cnt_b_r <= cnt_b_r + 1'b1;
						end
					end
					GPT_SPLIT: begin
						if (en_b && !frz_b) begin
							pcnt_b_r <= step_b ? pscl_b_r :
								pcnt_b_r - 1'b1; // [R21]
						end
						if (step_b) begin
							cnt_b_r <= zero_b ? load_b_r :
								cnt_b_r - 1'b1; // [R19]
						end
					end
					default: begin
						cnt_b_r <= cnt_b_r;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	// New events win over a clear in the same cycle
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			raw_r <= 9'h000;
		end else if (i_ce) begin
			raw_r <= (raw_r & ~(wr_clr ? i_wr_data[8:0] : 9'h000)) |
				set_raw; // [R09] [R15] [R20]
		end
	end

	// ****************************************
	// Interrupt
	// ****************************************
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq <= |(raw_r & mask_r); // [R15] [R20]
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_comb begin
		rd_nxt = 32'h00000000;
		case (i_addr)
			`GPT_OFS_CONFIG: rd_nxt[2:0] = cfg_r;
			`GPT_OFS_MODE_A: rd_nxt[1:0] = mode_a_r;
			`GPT_OFS_MODE_B: rd_nxt[1:0] = mode_b_r;
			`GPT_OFS_CONTROL: rd_nxt[9:0] = ctl_r;
			`GPT_OFS_MASK: rd_nxt[8:0] = mask_r;
			`GPT_OFS_RAW: rd_nxt[8:0] = raw_r;
			`GPT_OFS_MASKED: rd_nxt[8:0] = raw_r & mask_r; // [R09]
			`GPT_OFS_LOAD_A: begin
				rd_nxt = cfg == GPT_SPLIT ? {16'h0000, load_a_r} :
					{load_b_r, load_a_r};
			end
			`GPT_OFS_LOAD_B: rd_nxt[15:0] = load_b_r;
			`GPT_OFS_MATCH_A: rd_nxt = match_r;
			`GPT_OFS_PRESCALE_A: rd_nxt[7:0] = pscl_a_r;
			`GPT_OFS_PRESCALE_B: rd_nxt[7:0] = pscl_b_r;
			`GPT_OFS_VALUE_A: begin
				rd_nxt = cfg == GPT_SPLIT ? {16'h0000, cnt_a_r} :
					cnt_j; // [R05]
			end
			`GPT_OFS_VALUE_B: rd_nxt[15:0] = cnt_b_r;
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_rd_data <= 32'h00000000;
		end else if (i_ce) begin
			o_rd_data <= i_rd ? rd_nxt : 32'h00000000;
		end
	end
endmodule : gpt_top

/* File: test/gpt_top_properties.sv */
// Checker of the timer pair register port and interrupt output
`timescale 1ns/1ps
`include "gpt_map.svh"
module gpt_top_properties import gpt_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_halt,
	input wire logic i_capture_pin,
	input wire logic [31:0] o_rd_data,
	input wire logic o_irq
);
	// ****************************************
	// Shadows of the writable registers except control, clear, mode B and prescale B
	// ****************************************
	logic [2:0] cfg_r;
	logic [1:0] mode_r;
	logic [7:0] pre_r;
	logic [15:0] ld_a_r;
	logic [15:0] ld_b_r;
	logic [31:0] mask_r;
	logic [31:0] match_r;
	logic joined;
	assign joined = cfg_r <= 3'h1;
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_r <= 3'h0;
			mode_r <= 2'h0;
			pre_r <= 8'h00;
			ld_a_r <= 16'hFFFF;
			ld_b_r <= 16'hFFFF;
			mask_r <= 32'h0;
			match_r <= 32'hFFFFFFFF;
		end else if (i_ce && i_wr) begin
			case (i_addr)
				`GPT_OFS_CONFIG: cfg_r <= i_wr_data[2:0];
				`GPT_OFS_MODE_A: mode_r <= i_wr_data[1:0];
				`GPT_OFS_PRESCALE_A: pre_r <= i_wr_data[7:0];
				`GPT_OFS_MASK: mask_r <= i_wr_data & 32'h00000109;
				`GPT_OFS_MATCH_A: match_r <= i_wr_data;
				`GPT_OFS_LOAD_B: ld_b_r <= i_wr_data[15:0];
				`GPT_OFS_LOAD_A: begin
					ld_a_r <= i_wr_data[15:0];
					if (joined) begin
						ld_b_r <= i_wr_data[31:16];
					end
				end
				default: ;
			endcase
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	a_rd_idle_zero: assert property (
		!$past(i_rd) |-> o_rd_data == 32'h0) else $error("read data not idle");
	a_irq_needs_mask: assert property (
		o_irq |-> (mask_r | $past(mask_r)) != 32'h0)
		else $error("irq while masked");
	a_masked_in_mask: assert property (
		i_rd && i_ce && i_addr == `GPT_OFS_MASKED |=>
		(o_rd_data & ~(mask_r | $past(mask_r))) == 32'h0)
		else $error("masked bit");
	a_cfg_readback: assert property (
		i_rd && i_ce && i_addr == `GPT_OFS_CONFIG |=>
		o_rd_data == {29'h0, $past(cfg_r)}) else $error("config readback");
	a_load_joined: assert property (
		i_rd && i_ce && i_addr == `GPT_OFS_LOAD_A ##1 1'b1 |->
		o_rd_data == ($past(joined) ? {$past(ld_b_r), $past(ld_a_r)} :
		{16'h0, $past(ld_a_r)})) else $error("load readback");
	a_prescale_back: assert property (
		i_rd && i_ce && i_addr == `GPT_OFS_PRESCALE_A |=>
		o_rd_data[7:0] == $past(pre_r)) else $error("prescale readback");
	a_mode_back: assert property (
		i_rd && i_ce && i_addr == `GPT_OFS_MODE_A |=>
		o_rd_data == {30'h0, $past(mode_r)}) else $error("mode readback");
	a_match_back: assert property (
		i_rd && i_ce && i_addr == `GPT_OFS_MATCH_A |=>
		o_rd_data == $past(match_r)) else $error("match readback");
endmodule : gpt_top_properties

bind gpt_top gpt_top_properties i_gpt_top_properties (.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_wr_data(i_wr_data),
	.i_wr(i_wr), .i_rd(i_rd), .i_halt(i_halt), .i_capture_pin(i_capture_pin),
	.o_rd_data(o_rd_data), .o_irq(o_irq));

/* File: test/tb_gpt_top.sv */
// Self-checking testbench of the timer pair
`timescale 1ns/1ps
`include "gpt_map.svh"
module tb_gpt_top;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d;} gpt_row_t;
	logic i_ref_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_ce = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_halt = 1'b0;
	logic i_capture_pin = 1'b0;
	logic pin_on = 1'b0;
	logic [31:0] o_rd_data;
	logic o_irq;
	logic [31:0] v1;
	logic [31:0] v2;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	// Reads: d is the expected value; writes: d is the data
	gpt_row_t rows [18] = '{
		'{0, `GPT_OFS_CONFIG, 32'h0}, '{0, `GPT_OFS_MODE_A, 32'h0},
		'{0, `GPT_OFS_MODE_B, 32'h0}, '{0, `GPT_OFS_CONTROL, 32'h0},
		'{0, `GPT_OFS_MASK, 32'h0}, '{0, `GPT_OFS_RAW, 32'h0},
		'{0, `GPT_OFS_LOAD_A, 32'hFFFFFFFF}, '{0, `GPT_OFS_LOAD_B, 32'hFFFF},
		'{0, `GPT_OFS_PRESCALE_A, 32'h0}, '{0, `GPT_OFS_PRESCALE_B, 32'h0},
		'{0, `GPT_OFS_VALUE_A, 32'hFFFFFFFF}, '{0, `GPT_OFS_VALUE_B, 32'hFFFF},
		'{0, `GPT_OFS_MATCH_A, 32'hFFFFFFFF}, '{1, 8'h40, 32'h12345678},
		'{0, 8'h40, 32'h0}, '{1, `GPT_OFS_MASKED, 32'hFFFFFFFF},
		'{0, `GPT_OFS_MASKED, 32'h0}, '{0, `GPT_OFS_CONFIG, 32'h0}};

	gpt_top #(.RTC_DIV(4)) i_gpt_top (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_ce(i_ce), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
		.i_rd(i_rd), .i_halt(i_halt), .i_capture_pin(i_capture_pin),
		.o_rd_data(o_rd_data), .o_irq(o_irq));

	always #10 i_ref_clk = ~i_ref_clk;
	// ****************************************
	// Slow pin clock, still outside the clock test
	// ****************************************
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (pin_on && cyc % 4 == 0) begin
			i_capture_pin <= ~i_capture_pin;
		end
		if (cyc == 20000) begin
			// Blocking, so the verdict sees the timeout
			errors = errors + 1;
			end_sim();
		end
	end
	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 q = o_rd_data;
	endtask : rd
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		rd(a, q);
		chk(n, e, q);
	endtask : rdchk
	task automatic wait_irq(input int lim);
		int k;
		for (k = 0; k < lim && o_irq !== 1'b1; k++) begin
			@(posedge i_ref_clk);
		end
		chk("irq", 32'h1, {31'h0, o_irq});
	endtask : wait_irq
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else rdchk("row", rows[i].a, rows[i].d);
		end
		$display("test reset values done");
		wr(`GPT_OFS_MODE_A, 32'h1);
		wr(`GPT_OFS_MODE_B, 32'h2);
		wr(`GPT_OFS_LOAD_A, 32'h00030007);
		rdchk("value", `GPT_OFS_VALUE_A, 32'h00030007);
		rdchk("load_b", `GPT_OFS_LOAD_B, 32'h3);
		wr(`GPT_OFS_LOAD_A, 32'h5);
		wr(`GPT_OFS_MASK, 32'h1);
		wr(`GPT_OFS_CONTROL, 32'h1);
		wait_irq(40);
		rdchk("control", `GPT_OFS_CONTROL, 32'h0);
		rdchk("raw", `GPT_OFS_RAW, 32'h1);
		rdchk("masked", `GPT_OFS_MASKED, 32'h1);
		rdchk("reload", `GPT_OFS_VALUE_A, 32'h5);
		wr(`GPT_OFS_CLEAR, 32'h1);
		rdchk("cleared", `GPT_OFS_RAW, 32'h0);
		$display("test one-shot done");
		wr(`GPT_OFS_MODE_A, 32'h2);
		wr(`GPT_OFS_CONTROL, 32'h1);
		rd(`GPT_OFS_VALUE_A, v1);
		repeat (8) @(posedge i_ref_clk);
		rd(`GPT_OFS_VALUE_A, v2);
		chk("period", (v1 + 2) % 6, v2);
		@(posedge i_ref_clk);
		i_ce <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		i_ce <= 1'b1;
		rd(`GPT_OFS_VALUE_A, v1);
		chk("freeze", (v2 + 3) % 6, v1);
		@(posedge i_ref_clk);
		i_halt <= 1'b1;
		wr(`GPT_OFS_CONTROL, 32'h3);
		rd(`GPT_OFS_VALUE_A, v1);
		repeat (8) @(posedge i_ref_clk);
		rd(`GPT_OFS_VALUE_A, v2);
		chk("stall", v1, v2);
		@(posedge i_ref_clk);
		i_halt <= 1'b0;
		wr(`GPT_OFS_CONTROL, 32'h0);
		$display("test periodic and stall done");
		wr(`GPT_OFS_CONFIG, 32'h4);
		wr(`GPT_OFS_MODE_B, 32'h2);
		wr(`GPT_OFS_PRESCALE_A, 32'h2);
		wr(`GPT_OFS_LOAD_A, 32'd100);
		wr(`GPT_OFS_LOAD_B, 32'd200);
		wr(`GPT_OFS_CLEAR, 32'h109);
		wr(`GPT_OFS_CONTROL, 32'h101);
		rd(`GPT_OFS_VALUE_A, v1);
		repeat (28) @(posedge i_ref_clk);
		rd(`GPT_OFS_VALUE_A, v2);
		chk("split_a", v1 - 10, v2);
		rd(`GPT_OFS_VALUE_B, v1);
		repeat (28) @(posedge i_ref_clk);
		rd(`GPT_OFS_VALUE_B, v2);
		chk("split_b", v1 - 30, v2);
		wr(`GPT_OFS_MASK, 32'h100);
		wait_irq(300);
		rd(`GPT_OFS_RAW, v1);
		chk("raw_b", 32'h100, v1 & 32'h100);
		wr(`GPT_OFS_CLEAR, 32'h100);
		wr(`GPT_OFS_CONTROL, 32'h0);
		$display("test split done");
		wr(`GPT_OFS_CONFIG, 32'h1);
		rdchk("start", `GPT_OFS_VALUE_A, 32'h1);
		wr(`GPT_OFS_MATCH_A, 32'h3);
		wr(`GPT_OFS_MASK, 32'h8);
		i_halt <= 1'b1;
		pin_on <= 1'b1;
		wr(`GPT_OFS_CONTROL, 32'h313);
		wait_irq(400);
		rdchk("match", `GPT_OFS_MASKED, 32'h8);
		wr(`GPT_OFS_CLEAR, 32'h8);
		rdchk("match_clr", `GPT_OFS_RAW, 32'h0);
		@(posedge i_ref_clk);
		pin_on <= 1'b0;
		i_halt <= 1'b0;
		$display("test clock mode done");
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		rdchk("rst_cfg", `GPT_OFS_CONFIG, 32'h0);
		rdchk("rst_pre", `GPT_OFS_PRESCALE_A, 32'h0);
		rdchk("rst_val", `GPT_OFS_VALUE_A, 32'hFFFFFFFF);
		$display("test second reset done");
		end_sim();
	end
endmodule : tb_gpt_top
